// *** verilog/icr_bank.v ***
// Self-clearing action registers: interrupt clears, phase offset step
// strobes, profile-selection starts, forced timeouts; monitor overrides are held levels.
// Assumes one system clock; event inputs come from logic on that clock.
// Overview of operation
// - Clear sync, watchdog, storage interrupts; 7:4 unused
// - Clear the eight loop-state interrupts
// - Clear history, clamp, slew interrupts; 7:5 unused
// - Inputs one and two event clears
// - Inputs three and four event clears
// - Reset phase offset, bit self-clears
// - Decrement phase offset once, self-clears
// - Increment phase offset once, self-clears
// - Start profile selection per input
// - Start bits return to zero themselves
// - Force validation timeout per input, self-clears
// - Override monitor fault per input, default off
// - Bypass monitor per input, default off
// - Clear bit resets matching monitor bit
// - Monitor bits clear only by clears/reset
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "icr_map.vh"

module icr_bank #(
    parameter ADDR_W = 14 // Byte address width
)(
    input wire clk_i, // System clock, 20 MHz
    input wire rstn_i, // Synchronous reset, active low
    // AXI4-Lite write address
    input wire s_axi_awvalid, // Write address valid
    output wire s_axi_awready, // Write address ready
    input wire [ADDR_W-1:0] s_axi_awaddr, // Write byte address
    input wire [2:0] s_axi_awprot, // Unused protection
    // AXI4-Lite write data
    input wire s_axi_wvalid, // Write data valid
    output wire s_axi_wready, // Write data ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Byte strobes
    // AXI4-Lite write response
    output wire s_axi_bvalid, // Response valid
    input wire s_axi_bready, // Response ready
    output wire [1:0] s_axi_bresp, // Response code
    // AXI4-Lite read address
    input wire s_axi_arvalid, // Read address valid
    output wire s_axi_arready, // Read address ready
    input wire [ADDR_W-1:0] s_axi_araddr, // Read byte address
    input wire [2:0] s_axi_arprot, // Unused protection
    // AXI4-Lite read data
    output wire s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    output wire [31:0] s_axi_rdata, // Read data
    output wire [1:0] s_axi_rresp, // Read response code
    // Events into the interrupt monitor
    input wire [39:0] irq_event_i, // One-cycle event pulses
    // Strobes and levels to the loop and monitors
    output wire phase_rst_o, // Zero the phase offset
    output wire phase_dec_o, // Subtract one step
    output wire phase_inc_o, // Add one step
    output wire [3:0] prof_start_o, // Start profile selection
    output wire [3:0] tmo_force_o, // Force validation timeout
    output wire [3:0] mon_ovr_o, // Override monitor fault
    output wire [3:0] mon_byp_o, // Bypass monitor
    output wire irq_o // Level interrupt
);

    localparam NBYTE = 5; // Monitor bytes
    localparam [39:0] MASK_RST = `ICR_RST_MASK; // Mask reset, one byte per lane

    // Bus handshake state
    reg awready_q; // Address slot free
    reg wready_q; // Data slot free
    reg [ADDR_W-1:0] awaddr_q; // Captured write address
    reg [7:0] wbyte_q; // Captured low byte
    reg bvalid_q; // Write response pending
    reg [1:0] bresp_q; // Write response code
    reg arready_q; // Read slot free
    reg rvalid_q; // Read data pending
    reg [31:0] rdata_q; // Read data
    reg [1:0] rresp_q; // Read response code

    // Block state
    reg [39:0] mon_q; // Interrupt monitor
    reg [39:0] mask_q; // Interrupt mask
    reg [2:0] phase_q; // Phase strobes
    reg [3:0] start_q; // Profile start strobes
    reg [3:0] tmo_q; // Timeout strobes
    reg [3:0] ovr_q; // Override levels
    reg [3:0] byp_q; // Bypass levels
    reg irq_q; // Interrupt output

    // Write takes place once address and data are both held
    wire aw_full = ~awready_q; // Address captured
    wire w_full = ~wready_q; // Data captured
    wire wr_en = aw_full & w_full & ~bvalid_q; // Commit write
    wire [11:0] wr_idx = awaddr_q[13:2]; // Word index
    wire [11:0] rd_idx = s_axi_araddr[13:2]; // Read index
    wire wr_hit; // Write to a mapped word
    wire [39:0] clr_vec; // Per-bit clear strobes
    wire clr_all; // Global clear request

    // Bus signals straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Block outputs straight from flops
    assign phase_rst_o = phase_q[`ICR_BIT_PH_RST];
    assign phase_dec_o = phase_q[`ICR_BIT_PH_DEC];
    assign phase_inc_o = phase_q[`ICR_BIT_PH_INC];
    assign prof_start_o = start_q;
    assign tmo_force_o = tmo_q;
    assign mon_ovr_o = ovr_q;
    assign mon_byp_o = byp_q;
    assign irq_o = irq_q;

    // Write-address capture; freed after the response is taken
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            awready_q <= 1'b1;
            awaddr_q <= {ADDR_W{1'b0}};
        end
        else if (awready_q && s_axi_awvalid)
        begin
            // Hold address until the write response is taken
            awready_q <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            awready_q <= 1'b1;
        end
    end

    // Write-data capture; only the low byte carries bits
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            wready_q <= 1'b1;
            wbyte_q <= 8'h00;
        end
        else if (wready_q && s_axi_wvalid)
        begin
            wready_q <= 1'b0;
            // A cleared strobe reads as zero: no action taken
            wbyte_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            wready_q <= 1'b1;
        end
    end

    // Address decode of mapped writable words
    assign wr_hit = (wr_idx >= `ICR_IDX_RESET_FN && wr_idx <= `ICR_IDX_MON_BYP)
                  || (wr_idx >= `ICR_IDX_MASK_BASE && wr_idx < `ICR_IDX_MASK_BASE + 12'd5);

    // Write response; unmapped words answer SLVERR
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= `ICR_RESP_OKAY;
        end
        else if (wr_en)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `ICR_RESP_OKAY : `ICR_RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Global clear-all, self-clearing by nature of a strobe
    assign clr_all = wr_en && wr_idx == `ICR_IDX_RESET_FN
                   && wbyte_q[`ICR_BIT_CLR_ALL];

    // One byte lane of clears and mask per monitor byte
    genvar k;
    generate
        for (k = 0; k < NBYTE; k = k + 1)
        begin : g_byte
            // Clear register k maps one to one on monitor byte k
            wire hit = wr_en && wr_idx == `ICR_IDX_SYNC_WD_CLR + k;
            // Bytes 0 sync/wd/storage, 1 loop, 2 limit, 3-4 input pairs
            assign clr_vec[8*k +: 8] = hit ? wbyte_q : 8'h00;

            // Mask byte k, read/write
            always @(posedge clk_i)
            begin
                if (!rstn_i)
                begin
                    mask_q[8*k +: 8] <= MASK_RST[8*k +: 8];
                end
                else if (wr_en && wr_idx == `ICR_IDX_MASK_BASE + k)
                begin
                    mask_q[8*k +: 8] <= wbyte_q;
                end
            end
        end
    endgenerate

    // Interrupt monitor: set on unmasked events, cleared only by
    // clear bits, clear-all or reset; a set in the clearing cycle wins
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            mon_q <= 40'h00_0000_0000;
        end
        else
        begin
            // Unused bit positions never set
            mon_q <= ((clr_all ? 40'h00_0000_0000 : (mon_q & ~clr_vec))
                     | (irq_event_i & mask_q)) & `ICR_IRQ_VALID;
        end
    end

    // Level interrupt while any unmasked monitor bit stands
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(mon_q & mask_q);
        end
    end

    // Phase offset strobes last one cycle; the bit is never stored
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            phase_q <= 3'b000;
        end
        else if (wr_en && wr_idx == `ICR_IDX_PHASE_CTL)
        begin
            // Reset, decrement, increment; zero bits do nothing
            phase_q <= wbyte_q[2:0];
        end
        else
        begin
            phase_q <= 3'b000;
        end
    end

    // Profile-selection start strobes, one cycle each
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            start_q <= `ICR_RST_NIB;
        end
        else if (wr_en && wr_idx == `ICR_IDX_PROF_START)
        begin
            // Bit 3 fourth input down to bit 0 first input
            start_q <= wbyte_q[3:0];
        end
        else
        begin
            // Acted on in one cycle, then back to zero
            start_q <= `ICR_RST_NIB;
        end
    end

    // Forced validation timeout strobes
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            tmo_q <= `ICR_RST_NIB;
        end
        else if (wr_en && wr_idx == `ICR_IDX_TMO_FORCE)
        begin
            tmo_q <= wbyte_q[3:0];
        end
        else
        begin
            tmo_q <= `ICR_RST_NIB;
        end
    end

    // Override and bypass are levels: a one-cycle override would be
    // useless to a monitor that judges over many reference periods
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ovr_q <= `ICR_RST_NIB;
            byp_q <= `ICR_RST_NIB;
        end
        else if (wr_en && wr_idx == `ICR_IDX_MON_OVR)
        begin
            ovr_q <= wbyte_q[3:0];
        end
        else if (wr_en && wr_idx == `ICR_IDX_MON_BYP)
        begin
            byp_q <= wbyte_q[3:0];
        end
    end

    // Read mux; strobe registers always read zero
    reg [7:0] rd_byte; // Selected byte
    reg rd_hit; // Read of a mapped word
    integer j;
    always @*
    begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
        // Clear, spare, strobe and reset words exist but read zero
        if (rd_idx >= `ICR_IDX_RESET_FN && rd_idx <= `ICR_IDX_MON_BYP)
        begin
            rd_hit = 1'b1;
        end
        if (rd_idx == `ICR_IDX_MON_OVR)
        begin
            rd_byte = {4'h0, ovr_q};
        end
        else if (rd_idx == `ICR_IDX_MON_BYP)
        begin
            rd_byte = {4'h0, byp_q};
        end
        for (j = 0; j < NBYTE; j = j + 1)
        begin
            if (rd_idx == `ICR_IDX_MON_BASE + j)
            begin
                rd_byte = mon_q[8*j +: 8];
                rd_hit = 1'b1;
            end
            if (rd_idx == `ICR_IDX_MASK_BASE + j)
            begin
                rd_byte = mask_q[8*j +: 8];
                rd_hit = 1'b1;
            end
        end
    end

    // Read channel: one read at a time, answer the cycle after
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `ICR_RESP_OKAY;
        end
        else if (arready_q && s_axi_arvalid)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= rd_hit ? `ICR_RESP_OKAY : `ICR_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** include/icr_map.vh ***
// Register map and constants for the action-register bank.
// Assumes 32-bit AXI4-Lite words; byte address is four times the index.
`ifndef ICR_MAP_VH
`define ICR_MAP_VH

// Word indices of the documented action registers
`define ICR_IDX_SYNC_WD_CLR 12'hA05
`define ICR_IDX_LOOP_CLR 12'hA06
`define ICR_IDX_LIMIT_CLR 12'hA07
`define ICR_IDX_PAIR1_CLR 12'hA08
`define ICR_IDX_PAIR2_CLR 12'hA09
`define ICR_IDX_SPARE_A 12'hA0A
`define ICR_IDX_SPARE_B 12'hA0B
`define ICR_IDX_PHASE_CTL 12'hA0C
`define ICR_IDX_PROF_START 12'hA0D
`define ICR_IDX_TMO_FORCE 12'hA0E
`define ICR_IDX_MON_OVR 12'hA0F
`define ICR_IDX_MON_BYP 12'hA10

// Global reset-functions register and its clear-all bit
`define ICR_IDX_RESET_FN 12'hA03
`define ICR_BIT_CLR_ALL 1

// Interrupt monitor bytes (read only) and mask bytes
`define ICR_IDX_MON_BASE 12'hD03
`define ICR_IDX_MASK_BASE 12'hA20

// Phase offset control bits
`define ICR_BIT_PH_RST 2
`define ICR_BIT_PH_DEC 1
`define ICR_BIT_PH_INC 0

// Implemented bits of the five monitor bytes, low byte first
`define ICR_IRQ_VALID 40'hFF_FF1F_FF0F

// Reset values
`define ICR_RST_MASK 40'hFF_FFFF_FFFF
`define ICR_RST_NIB 4'h0

// AXI response codes
`define ICR_RESP_OKAY 2'b00
`define ICR_RESP_SLVERR 2'b10

`endif

// *** tb/icr_bank_properties.sv ***
// Checker for the action-register bank: strobe widths, level changes, write response.
// Assumes it is bound onto icr_bank and shares its clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module icr_bank_props #(
    parameter ADDR_W = 14 // Byte address width
)(
    input wire clk_i, // System clock
    input wire rstn_i, // Reset, active low
    input wire s_axi_awvalid, // AW valid
    input wire s_axi_awready, // AW ready
    input wire s_axi_wvalid, // W valid
    input wire s_axi_wready, // W ready
    input wire s_axi_bvalid, // B valid
    input wire [39:0] irq_event_i, // Event pulses
    input wire phase_rst_o, // Zero offset
    input wire phase_dec_o, // Step down
    input wire phase_inc_o, // Step up
    input wire [3:0] prof_start_o, // Profile starts
    input wire [3:0] tmo_force_o, // Forced timeouts
    input wire [3:0] mon_ovr_o, // Overrides
    input wire [3:0] mon_byp_o, // Bypasses
    input wire irq_o // Interrupt
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    // Both halves of one write taken at the same edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    rst_pulse_a: assert property (phase_rst_o |=> !phase_rst_o)
        else $error("offset zeroing strobe too long");
    dec_pulse_a: assert property (phase_dec_o |=> !phase_dec_o)
        else $error("step-down strobe too long");
    inc_pulse_a: assert property (phase_inc_o |=> !phase_inc_o)
        else $error("step-up strobe too long");
    start_on_write_a: assert property (|prof_start_o |-> s_axi_bvalid)
        else $error("profile start without a committed write");
    start_self_clear_a: assert property (|prof_start_o |=> prof_start_o == 4'h0)
        else $error("profile start did not clear");
    tmo_self_clear_a: assert property (|tmo_force_o |=> (tmo_force_o == 4'h0) [*2])
        else $error("forced timeout did not clear");
    // Levels only move on the commit edge, which also raises the response
    levels_on_write_a: assert property ($changed(mon_ovr_o) || $changed(mon_byp_o)
        |-> s_axi_bvalid)
        else $error("override or bypass moved without a write");
    irq_from_event_a: assert property ($rose(irq_o) |-> $past(|irq_event_i, 2))
        else $error("interrupt rose without an event");
    write_resp_a: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
endmodule
bind icr_bank icr_bank_props #(.ADDR_W(ADDR_W)) i_props (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .irq_event_i(irq_event_i),
    .phase_rst_o(phase_rst_o),
    .phase_dec_o(phase_dec_o),
    .phase_inc_o(phase_inc_o),
    .prof_start_o(prof_start_o),
    .tmo_force_o(tmo_force_o),
    .mon_ovr_o(mon_ovr_o),
    .mon_byp_o(mon_byp_o),
    .irq_o(irq_o)
);
`default_nettype wire

// *** tb/tb_icr_bank.sv ***
// Self-checking bench for the action-register bank over AXI4-Lite.
// Assumes icr_map.vh on the include path; the bench alone drives every input.
`timescale 1ns/1ps
`default_nettype none
`include "icr_map.vh"
module tb_icr_bank;
    localparam logic [39:0] VALID = `ICR_IRQ_VALID; // Implemented monitor bits
    logic clk_i = 1'b0; // System clock
    logic rstn_i = 1'b0; // Reset, active low
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0; // Handshakes
    logic [13:0] awaddr = 14'h0000, araddr = 14'h0000; // Byte addresses
    logic [31:0] wdata = 32'h0000_0000; // Write data
    logic [3:0] wstrb = 4'hF; // Write byte strobes
    logic [39:0] evt = 40'h0; // Event pulses
    wire awr, wrd, bv, arr, rv, irq, ph_rst, ph_dec, ph_inc; // Design outputs
    wire [1:0] bresp, rresp; // Responses
    wire [31:0] rdata; // Read data
    wire [3:0] prof, tmo, ovr, byp; // Per-input outputs
    wire [10:0] st = {ph_rst, ph_dec, ph_inc, prof, tmo}; // Strobe bundle
    int err_total = 0; // Mismatches
    int check_count = 0; // Comparisons
    int cnt[11]; // Pulses seen per strobe
    int snap[11]; // Counts before an access

    icr_bank i_dut (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .irq_event_i(evt), .phase_rst_o(ph_rst),
        .phase_dec_o(ph_dec), .phase_inc_o(ph_inc), .prof_start_o(prof),
        .tmo_force_o(tmo), .mon_ovr_o(ovr), .mon_byp_o(byp), .irq_o(irq)
    );

    // Free-running 20 MHz clock
    initial forever #25 clk_i = ~clk_i;

    // Count every strobe cycle, so a pulse held two cycles shows up
    always @(posedge clk_i)
        for (int i = 0; i < 11; i++) cnt[i] <= cnt[i] + st[i];

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // A wait that ran out ends the run as a failure
    task automatic guard(input int n);
        if (n < 40) return;
        err_total++;
        end_sim;
    endtask

    // Write with address and data offered together; bready held throughout
    task automatic axw(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_i);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
            if (bv) break;
        end
        bry <= 1'b0;
        guard(n);
        chk(bresp, er);
    endtask

    task automatic axr(input logic [11:0] idx, input logic [7:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk_i);
        araddr <= {idx, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk_i);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        rry <= 1'b0;
        guard(n);
        chk(rresp, er);
        chk(rdata, {24'h00_0000, ed});
    endtask

    // Write an action byte, demand exactly the expected pulses, read back zero
    task automatic act(input logic [11:0] idx, input logic [7:0] d, input logic [10:0] ev);
        logic [10:0] dv;
        snap = cnt;
        axw(idx, d, `ICR_RESP_OKAY);
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 11; i++) dv[i] = (cnt[i] - snap[i]) == int'(ev[i]);
        chk(dv, 11'h7FF);
        axr(idx, 8'h00, `ICR_RESP_OKAY);
    endtask

    task automatic pulse(input logic [39:0] e);
        @(posedge clk_i);
        evt <= e;
        @(posedge clk_i);
        evt <= 40'h0;
    endtask

    initial
    begin
        logic v;
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        chk({irq, ovr, byp}, 9'h000);
        for (int b = 0; b < 3; b++)
            act(`ICR_IDX_PHASE_CTL, 8'h01 << b, 11'h100 << b);
        act(`ICR_IDX_PHASE_CTL, 8'hF8, 11'h000);
        for (int b = 0; b < 4; b++)
            act(`ICR_IDX_PROF_START, 8'h01 << b, 11'h010 << b);
        act(`ICR_IDX_PROF_START, 8'hF0, 11'h000);
        // Low byte strobe off: the write must act on nothing
        wstrb <= 4'hE;
        act(`ICR_IDX_PROF_START, 8'h0F, 11'h000);
        wstrb <= 4'hF;
        for (int b = 0; b < 4; b++)
            act(`ICR_IDX_TMO_FORCE, 8'h01 << b, 11'h001 << b);
        act(`ICR_IDX_TMO_FORCE, 8'h0F, 11'h00F);
        axw(`ICR_IDX_MON_OVR, 8'h05, `ICR_RESP_OKAY);
        axw(`ICR_IDX_MON_BYP, 8'h0A, `ICR_RESP_OKAY);
        chk({ovr, byp}, 8'h5A);
        axr(`ICR_IDX_MON_OVR, 8'h05, `ICR_RESP_OKAY);
        axr(`ICR_IDX_MON_BYP, 8'h0A, `ICR_RESP_OKAY);
        // Every monitor bit: set if implemented, survive a clear of the other bits, then clear
        for (int k = 0; k < 5; k++)
            for (int b = 0; b < 8; b++)
            begin
                v = VALID[8 * k + b];
                pulse(40'h1 << (8 * k + b));
                axr(`ICR_IDX_MON_BASE + k, {7'h00, v} << b, `ICR_RESP_OKAY);
                chk(irq, v);
                axw(`ICR_IDX_SYNC_WD_CLR + k, ~(8'h01 << b), `ICR_RESP_OKAY);
                axr(`ICR_IDX_MON_BASE + k, {7'h00, v} << b, `ICR_RESP_OKAY);
                axw(`ICR_IDX_SYNC_WD_CLR + k, 8'h01 << b, `ICR_RESP_OKAY);
                axr(`ICR_IDX_MON_BASE + k, 8'h00, `ICR_RESP_OKAY);
                chk(irq, 1'b0);
            end
        // Clear words are strobes and read back as zero
        axr(`ICR_IDX_PAIR2_CLR, 8'h00, `ICR_RESP_OKAY);
        // Masked event never reaches the monitor
        axw(`ICR_IDX_MASK_BASE, 8'h00, `ICR_RESP_OKAY);
        pulse(40'h8);
        axr(`ICR_IDX_MON_BASE, 8'h00, `ICR_RESP_OKAY);
        chk(irq, 1'b0);
        axw(`ICR_IDX_MASK_BASE, 8'hFF, `ICR_RESP_OKAY);
        // Global clear-all empties two bytes at once
        pulse(40'h80_0000_0100);
        axr(`ICR_IDX_MON_BASE + 1, 8'h01, `ICR_RESP_OKAY);
        axr(`ICR_IDX_MON_BASE + 4, 8'h80, `ICR_RESP_OKAY);
        axw(`ICR_IDX_RESET_FN, 8'h02, `ICR_RESP_OKAY);
        axr(`ICR_IDX_MON_BASE + 1, 8'h00, `ICR_RESP_OKAY);
        axr(`ICR_IDX_MON_BASE + 4, 8'h00, `ICR_RESP_OKAY);
        // Unmapped and read-only places
        axw(12'h100, 8'h01, `ICR_RESP_SLVERR);
        axr(12'h100, 8'h00, `ICR_RESP_SLVERR);
        axw(`ICR_IDX_MON_BASE, 8'hFF, `ICR_RESP_SLVERR);
        axr(`ICR_IDX_SPARE_A, 8'h00, `ICR_RESP_OKAY);
        // Second reset drops the held levels and restores the mask
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        chk({ovr, byp}, 8'h00);
        rstn_i <= 1'b1;
        axr(`ICR_IDX_MASK_BASE, 8'hFF, `ICR_RESP_OKAY);
        axr(`ICR_IDX_MON_OVR, 8'h00, `ICR_RESP_OKAY);
        end_sim;
    end
endmodule
`default_nettype wire
